// ---- common/acmp_pkg.sv ----
// Package for the dual analog comparator control block
package acmp_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ACMP_FIRST_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACMP_SECOND_CTRL_OFS = 8'h04;
  localparam logic [7:0] ACMP_SHARED_CTRL_OFS = 8'h08;
  localparam logic [7:0] ACMP_EVENT_OFS = 8'h0C;
  localparam logic [7:0] ACMP_SLEEP_OFS = 8'h10;
  // ==========================================================
  // Control register fields
  localparam int ACMP_ON_BIT = 7;
  localparam int ACMP_RESULT_BIT = 6;
  localparam int ACMP_OE_BIT = 5;
  localparam int ACMP_POL_BIT = 4;
  localparam int ACMP_SPEED_BIT = 3;
  localparam int ACMP_NINV_BIT = 2;
  localparam int ACMP_SEL_LSB = 0;
  // Shared register: mirrored results in bits 7:6
  localparam int ACMP_MIRROR1_BIT = 7;
  localparam int ACMP_MIRROR2_BIT = 6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] ACMP_CTRL_RST = 8'h08;
  localparam logic [7:0] ACMP_SHARED_RST = 8'h00;
  localparam logic [7:0] ACMP_WRITABLE_MASK = 8'hBF;
  localparam logic [5:0] ACMP_SHARED_MASK = 6'h3F;
  // Four-phase system clock: counter values of phases one and three
  localparam logic [1:0] ACMP_PHASE_ONE = 2'h0;
  localparam logic [1:0] ACMP_PHASE_THREE = 2'h2;

  typedef struct packed {
    logic on;
    logic oe;
    logic pol;
    logic speed;
    logic ninv;
    logic [1:0] sel;
  } acmp_ctrl_t;

  typedef enum logic [1:0] {
    ACMP_IDLE = 2'b01,
    ACMP_ACCESS = 2'b10
  } acmp_apb_state_t;
endpackage

// ---- logic/acmp_top.sv ----
// Dual analog comparator control logic with an APB register port
`timescale 1ns/1ps
// Behaviour
// - Raw comparator output is high when the plus input exceeds the minus input while the comparator is on.
// - The on bit enables a comparator; clear puts it in lowest current.
// - A two-bit field routes one of four pins to the inverting input.
// - A disabled first comparator feeds zero to the change detector.
// - Change latches are clocked on phases one and three of four.
// - In sleep the phase-one enable of the sampling latch is held high.
// - Each comparator has a control register; the second has a shared one.
// - Reference latch loads on the next phase three after a control access; sampler each phase one; mismatch edge sets the flag.
// - Polarity inverts the result; when off the result equals polarity.
// - Pin is driven only with output enable, direction clear and on.
// - Reset returns all control registers to reset values, comparators off.
module acmp_top
  import acmp_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [1:0] I_CMP_RAW,
  input wire logic I_SLEEP,
  input wire logic [1:0] I_PIN_DIRECTION,
  output logic [1:0] O_COMPARATOR_ON,
  output logic [1:0] O_SPEED_SELECT,
  output logic [1:0] O_NONINVERTING_SOURCE_SELECT,
  output logic [3:0] O_INVERTING_INPUT_SELECT_1,
  output logic [3:0] O_INVERTING_INPUT_SELECT_2,
  output logic [1:0] O_CMP_PIN_O,
  output logic [1:0] O_CMP_PIN_OE,
  output logic [1:0] O_COMPARATOR_EVENT_FLAG
);
  // ==========================================================
  // Control registers
  acmp_ctrl_t ctrl_q [2];
  logic [5:0] shared_q;
  logic [1:0] flag_q;
  logic [1:0] phase_q;
  logic [1:0] sync1_q, sync2_q, samp_q, ref_q, mis_q;
  logic [1:0] rd_pend_q;

  wire wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  wire rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  wire acc = I_PSEL && I_PENABLE;
  wire hit_c1 = I_PADDR == ACMP_FIRST_CTRL_OFS;
  wire hit_c2 = I_PADDR == ACMP_SECOND_CTRL_OFS;
  wire hit_sh = I_PADDR == ACMP_SHARED_CTRL_OFS;
  wire hit_ev = I_PADDR == ACMP_EVENT_OFS;
  wire hit_sl = I_PADDR == ACMP_SLEEP_OFS;
  wire mapped = hit_c1 | hit_c2 | hit_sh | hit_ev | hit_sl;
  wire [1:0] ctrl_hit = {hit_c2, hit_c1};
  wire phase_one = phase_q == ACMP_PHASE_ONE;
  wire phase_three = phase_q == ACMP_PHASE_THREE;

  // Single-cycle APB slave; unmapped addresses answer with an error
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && !mapped;

  // ==========================================================
  // Four-phase system clock
  // phase counter
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ==========================================================
  // Per-comparator logic
  logic [1:0] result;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= I_CMP_RAW[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
      assign result[g] = ctrl_q[g].on ? (sync2_q[g] ^ ctrl_q[g].pol)
                                      : ctrl_q[g].pol;
      // first comparator forced to zero when off
      wire det_in = (g == 0 && !ctrl_q[g].on) ? 1'b0 : result[g];
      wire samp_en = phase_one || I_SLEEP;
      // reference latch load on phase three after access
      wire ref_en = phase_three && rd_pend_q[g];
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          samp_q[g] <= 1'b0;
          ref_q[g] <= 1'b0;
          mis_q[g] <= 1'b0;
        end else begin
          if (samp_en) samp_q[g] <= det_in;
          if (ref_en) ref_q[g] <= det_in;
          mis_q[g] <= samp_q[g] ^ ref_q[g];
        end
      end
      wire mis_rise = (samp_q[g] ^ ref_q[g]) && !mis_q[g];
      wire flag_clr = wr_acc && hit_ev && !I_PWDATA[g];
      wire flag_set = wr_acc && hit_ev && I_PWDATA[g];
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          flag_q[g] <= 1'b0;
        end else if (mis_rise || flag_set) begin
          flag_q[g] <= 1'b1;
        end else if (flag_clr) begin
          flag_q[g] <= 1'b0;
        end
      end
      // Pending reference load, held until the next phase three
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          rd_pend_q[g] <= 1'b0;
        end else if (acc && ctrl_hit[g]) begin
          rd_pend_q[g] <= 1'b1;
        end else if (phase_three) begin
          rd_pend_q[g] <= 1'b0;
        end
      end
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          ctrl_q[g] <= '{on: ACMP_CTRL_RST[ACMP_ON_BIT],
                         oe: ACMP_CTRL_RST[ACMP_OE_BIT],
                         pol: ACMP_CTRL_RST[ACMP_POL_BIT],
                         speed: ACMP_CTRL_RST[ACMP_SPEED_BIT],
                         ninv: ACMP_CTRL_RST[ACMP_NINV_BIT],
                         sel: ACMP_CTRL_RST[1:0]};
        end else if (wr_acc && ctrl_hit[g]) begin
          ctrl_q[g] <= '{on: I_PWDATA[ACMP_ON_BIT],
                         oe: I_PWDATA[ACMP_OE_BIT],
                         pol: I_PWDATA[ACMP_POL_BIT],
                         speed: I_PWDATA[ACMP_SPEED_BIT],
                         ninv: I_PWDATA[ACMP_NINV_BIT],
                         sel: I_PWDATA[ACMP_SEL_LSB +: 2]};
        end
      end
      assign O_COMPARATOR_ON[g] = ctrl_q[g].on;
      assign O_SPEED_SELECT[g] = ctrl_q[g].speed;
      assign O_NONINVERTING_SOURCE_SELECT[g] = ctrl_q[g].ninv;
      always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          O_CMP_PIN_O[g] <= 1'b0;
          O_CMP_PIN_OE[g] <= 1'b0;
        end else begin
          O_CMP_PIN_O[g] <= result[g];
          O_CMP_PIN_OE[g] <= ctrl_q[g].oe && !I_PIN_DIRECTION[g]
                             && ctrl_q[g].on;
        end
      end
    end
  endgenerate

  assign O_INVERTING_INPUT_SELECT_1 = 4'h1 << ctrl_q[0].sel;
  assign O_INVERTING_INPUT_SELECT_2 = 4'h1 << ctrl_q[1].sel;
  assign O_COMPARATOR_EVENT_FLAG = flag_q;

  // ==========================================================
  // Shared register (timer interaction bits kept as storage)
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      shared_q <= ACMP_SHARED_RST[5:0];
    end else if (wr_acc && hit_sh) begin
      shared_q <= I_PWDATA[5:0] & ACMP_SHARED_MASK;
    end
  end

  // ==========================================================
  // Read data
  function automatic logic [7:0] ctrl_word(acmp_ctrl_t c, logic r);
    ctrl_word = {c.on, r, c.oe, c.pol, c.speed, c.ninv, c.sel};
  endfunction
  wire [7:0] c1_rd = ctrl_word(ctrl_q[0], result[0]);
  wire [7:0] c2_rd = ctrl_word(ctrl_q[1], result[1]);
  wire [7:0] sh_rd = {result[0], result[1], shared_q};
  wire [7:0] rd_mux = hit_c1 ? c1_rd : hit_c2 ? c2_rd : hit_sh ? sh_rd :
                      hit_ev ? {6'h00, flag_q} :
                      hit_sl ? {7'h00, I_SLEEP} : 8'h00;
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Checks
  property p_off_level;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      !ctrl_q[0].on |-> result[0] == ctrl_q[0].pol;
  endproperty
  a_off_level: assert property (p_off_level)
    else $error("off level");
  property p_pin_gate;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      O_CMP_PIN_OE[0] |->
        $past(ctrl_q[0].on && ctrl_q[0].oe && !I_PIN_DIRECTION[0]);
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("pin driven while gated");
  property p_flag_set;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      (samp_q[0] != ref_q[0]) && !mis_q[0] |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("mismatch flag missed");
  // Clear only sticks when no new mismatch edge arrives with it
  property p_flag_clr;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      wr_acc && hit_ev && !I_PWDATA[0]
        && !((samp_q[0] ^ ref_q[0]) && !mis_q[0]) |=> !flag_q[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("event flag not cleared");
  property p_sleep_samp;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      I_SLEEP && ctrl_q[1].on |=> samp_q[1] == $past(result[1]);
  endproperty
  a_sleep_samp: assert property (p_sleep_samp)
    else $error("sampler not transparent in sleep");
  property p_sync;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CMP_RAW[0] ##1 I_CMP_RAW[0] |=> sync2_q[0];
  endproperty
  a_sync: assert property (p_sync)
    else $error("synchroniser latency wrong");
  property p_zero_det;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      !ctrl_q[0].on && phase_one ##1 !ctrl_q[0].on |-> !samp_q[0];
  endproperty
  a_zero_det: assert property (p_zero_det)
    else $error("detector input not zero");
  property p_phase;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      phase_one |-> ##2 phase_three;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase order wrong");
  property p_write;
    @(posedge I_MCLK) disable iff (!I_RSTN)
      wr_acc && hit_c2 |=> ctrl_q[1].on == $past(I_PWDATA[ACMP_ON_BIT]);
  endproperty
  a_write: assert property (p_write)
    else $error("on bit not written");
  c_flag: cover property (@(posedge I_MCLK) $rose(flag_q[0]));
  c_pin: cover property (@(posedge I_MCLK) $rose(O_CMP_PIN_OE[0]));
  c_sleep: cover property (@(posedge I_MCLK) I_SLEEP && $rose(samp_q[1]));
endmodule // acmp_top

// ---- tb/acmp_analog_model.sv ----
// Analog side: input pins and voltages feeding both comparators
`timescale 1ns/1ps
module acmp_analog_model (
  input wire logic [1:0] i_on,
  input wire logic [3:0] i_sel_1,
  input wire logic [3:0] i_sel_2,
  input wire logic [15:0] i_plus_1,
  input wire logic [15:0] i_plus_2,
  output logic [1:0] o_raw
);
  // ============================================
  // Inverting pins, millivolts
  function automatic logic [15:0] minus_mv(input logic [3:0] s);
    case (s)
      4'h1: minus_mv = 16'h0064;
      4'h2: minus_mv = 16'h00C8;
      4'h4: minus_mv = 16'h012C;
      4'h8: minus_mv = 16'h0190;
      default: minus_mv = 16'h0000;
    endcase
  endfunction
  assign o_raw[0] = (i_plus_1 > minus_mv(i_sel_1)) ^ !i_on[0];
  assign o_raw[1] = (i_plus_2 > minus_mv(i_sel_2)) ^ !i_on[1];
endmodule // acmp_analog_model

// ---- tb/tb.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb import acmp_pkg::*; ;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, slp = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, r;
  logic prdy, perr, e;
  logic [1:0] raw, on, spd, nsrc, pin_o, pin_oe, flag, dir = 2'h3;
  logic [3:0] is1, is2;
  logic [15:0] p1 = 16'h0000, p2 = 16'h0000;
  int bad_count = 0, comparisons = 0;
  always #20 clk = ~clk;
  acmp_top dut (.I_MCLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pwd),
    .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_CMP_RAW(raw), .I_SLEEP(slp), .I_PIN_DIRECTION(dir),
    .O_COMPARATOR_ON(on), .O_SPEED_SELECT(spd),
    .O_NONINVERTING_SOURCE_SELECT(nsrc),
    .O_INVERTING_INPUT_SELECT_1(is1), .O_INVERTING_INPUT_SELECT_2(is2),
    .O_CMP_PIN_O(pin_o), .O_CMP_PIN_OE(pin_oe),
    .O_COMPARATOR_EVENT_FLAG(flag));
  acmp_analog_model model (.i_on(on), .i_sel_1(is1), .i_sel_2(is2),
    .i_plus_1(p1), .i_plus_2(p2), .o_raw(raw));
  // ============================================
  // Bus and check tasks
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pw <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    if (prdy !== 1'b1) begin
      bad_count++;
      $display("ERROR pready expected 1 seen %b", prdy);
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ============================================
  // Watchdog, far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(0, 8'h00, 0); chk("ctrl1", 32'h08, r);
    apb(0, 8'h04, 0); chk("ctrl2", 32'h08, r);
    apb(0, 8'h08, 0); chk("shared", 32'h0, r);
    apb(0, 8'h14, 0); chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, r);
    chk("speed", 32'h3, {30'h0, spd});
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h00, 32'h88 | s);
      apb(1, 8'h04, 32'h8C | s);
      // Let the write edge settle before looking
      @(negedge clk);
      chk("isel1", 32'h1 << s, {28'h0, is1});
      chk("isel2", 32'h1 << s, {28'h0, is2});
    end
    chk("nsrc", 32'h2, {30'h0, nsrc});
    apb(1, 8'h00, 32'h18); apb(0, 8'h00, 0);
    chk("off_pol", 32'h1, {31'h0, r[6]});
    chk("on", 32'h2, {30'h0, on});
    p1 <= 16'd350;
    apb(1, 8'h00, 32'h8A); repeat (8) @(posedge clk);
    apb(0, 8'h00, 0); chk("res1", 32'h1, {31'h0, r[6]});
    apb(1, 8'h00, 32'h9A); repeat (8) @(posedge clk);
    apb(0, 8'h08, 0); chk("mirror", 32'h0, {31'h0, r[7]});
    apb(1, 8'h00, 32'hAA); dir <= 2'h2; repeat (4) @(posedge clk);
    chk("pin_oe", 32'h1, {31'h0, pin_oe[0]});
    chk("pin_o", 32'h1, {31'h0, pin_o[0]});
    dir <= 2'h3; repeat (4) @(posedge clk);
    chk("pin_off", 32'h0, {31'h0, pin_oe[0]});
    apb(0, 8'h00, 0); apb(1, 8'h0C, 0);
    p1 <= 16'd250; repeat (12) @(posedge clk);
    chk("flag1", 32'h1, {31'h0, flag[0]});
    apb(0, 8'h0C, 0); chk("evreg", 32'h1, {31'h0, r[0]});
    // Off with polarity set: result is high, detector must still see zero
    apb(1, 8'h00, 32'h1A); apb(1, 8'h0C, 0);
    p1 <= 16'd350; repeat (12) @(posedge clk);
    chk("off_flag", 32'h0, {31'h0, flag[0]});
    chk("off_det", 32'h0, {31'h0, dut.samp_q[0]});
    slp <= 1'b1; p2 <= 16'd100;
    apb(1, 8'h04, 32'h89); repeat (8) @(posedge clk);
    apb(0, 8'h04, 0); apb(1, 8'h0C, 0);
    // Two sync edges, one sampler edge, one flag edge: no phase wait
    p2 <= 16'd300; repeat (4) @(posedge clk);
    @(negedge clk);
    chk("sleep_flag", 32'h2, {30'h0, flag});
    rstn <= 1'b0; @(posedge clk);
    chk("rst_on", 32'h0, {30'h0, on});
    finish_test;
  end
endmodule // tb
